// file: hdl/s_bus_layer1_multiframe_ctrl.sv
/*
  S/T layer-1 control for the network side: multiframe with S/Q
  access, B/D transfer to the serial highway, loopback 2, activation
  state machine or software control, test pulses, indications.
  Assumes a frame-level deframer/framer beside it on clk and an
  AXI4-Lite master; control channel pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module s_bus_layer1_multiframe_ctrl #(
  parameter int BIT_CYCLES_P = s_l1_pkg::BIT_CYCLES,
  parameter int DEACT_CYCLES_P = s_l1_pkg::DEACT_CYCLES
) (
  input wire logic clk, // 250 MHz clock
  input wire logic rst, // synchronous reset, high
  input wire logic [s_l1_pkg::AXI_ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [s_l1_pkg::AXI_ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [3:0] ci_cmd_pin, // control channel command
  input wire logic d_block_pin, // highway blocks D access
  output logic [3:0] ci_ind, // control channel indication
  input wire logic [7:0] hw_b1_in, // highway B1 toward line
  input wire logic [7:0] hw_b2_in, // highway B2 toward line
  input wire logic [1:0] hw_d_in, // highway D toward line
  output logic [7:0] hw_b1_out, // B1 toward highway
  output logic [7:0] hw_b2_out, // B2 toward highway
  output logic [1:0] hw_d_out, // D toward highway
  input wire logic rx_frame_valid, // deframer frame pulse
  input wire logic [1:0] rx_info, // received info class
  input wire logic rx_fa, // received aux framing bit
  input wire logic [7:0] rx_b1, // received B1
  input wire logic [7:0] rx_b2, // received B2
  input wire logic [1:0] rx_d, // received D
  output logic tx_frame_start, // framer frame pulse
  output logic [2:0] tx_info, // transmit info select
  output logic [7:0] tx_b1, // line B1
  output logic [7:0] tx_b2, // line B2
  output logic [1:0] tx_d, // line D
  output logic [1:0] tx_e, // line D echo
  output logic tx_fa, // line aux framing bit
  output logic tx_m, // line multiframe bit
  output logic tx_s, // line S bit
  output logic tx_pulse_p, // test pulse, positive
  output logic tx_pulse_n, // test pulse, negative
  output logic loop2_closed, // loopback 2 active
  output logic multiframe_tick_irq, // once per multiframe
  output logic q_change_irq, // received Q changed
  output logic receive_status_change_irq // line status changed
);
  import s_l1_pkg::*;

  localparam int CW = $clog2(BIT_CYCLES_P);
  localparam int TW = $clog2(DEACT_CYCLES_P + 1);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES_P - 1);
  localparam logic [5:0] FB_LAST = 6'(FRAME_BITS - 1);
  localparam logic [2:0] SUB_LAST = 3'(SUB_FRAMES - 1);
  localparam logic [1:0] SLOT_LAST = 2'(S_SLOTS - 1);
  localparam logic [TW-1:0] TMR_LAST = TW'(DEACT_CYCLES_P);
  localparam logic [2:0] MUTE_INIT = 3'(LOOP_MUTE_FRAMES);

  typedef struct packed {
    logic [CW-1:0] bit_cyc;
    logic [5:0] bit_idx;
    logic frame_start;
    logic [2:0] sub;
    logic [1:0] slot;
    l1_state_e st;
    logic [TW-1:0] tmr;
    logic [3:0] prev_cmd;
    logic [1:0] warm;
    logic [2:0] mute;
    logic pol_single;
    logic pol_cont;
    logic [3:0] cfg;
    logic [2:0] lcmd;
    logic [4:0] sqtx;
    logic [3:0] s_act;
    logic [3:0] q_sh;
    logic [3:0] q_rx;
    logic [2:0] stat;
    logic mf_irq;
    logic qc_irq;
    logic rsc_irq;
    logic [7:0] rx_b1_l;
    logic [7:0] rx_b2_l;
    logic [1:0] rx_d_l;
    logic [3:0] ci_ind;
    logic [2:0] tx_info;
    logic [7:0] tx_b1;
    logic [7:0] tx_b2;
    logic [1:0] tx_d;
    logic [1:0] tx_e;
    logic tx_fa;
    logic tx_m;
    logic tx_s;
    logic pp;
    logic pn;
    logic [7:0] hw_b1;
    logic [7:0] hw_b2;
    logic [1:0] hw_d;
    logic loop;
    logic aw_h;
    logic [AXI_ADDR_W-1:0] awa;
    logic w_h;
    logic [7:0] wd;
    logic ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [7:0] rd;
    logic [1:0] rr;
  } ctrl_s;

  ctrl_s s_ff;
  ctrl_s nxt_s;
  logic [4:0] sync_q;
  logic [3:0] cmd;
  logic d_blk;

  pin_sync2 #(.W(5)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({d_block_pin, ci_cmd_pin}),
    .q(sync_q)
  );
  assign cmd = sync_q[3:0];
  assign d_blk = sync_q[4];

  always_comb begin
    logic bit_end;
    logic ft;
    logic sw;
    logic mf_en;
    logic non_idle;
    logic expired;
    logic xp;
    logic loop;
    logic mute;
    logic test_cmd;
    logic [2:0] txi;
    bit_end = 1'b0;
    ft = 1'b0;
    sw = 1'b0;
    mf_en = 1'b0;
    non_idle = 1'b0;
    expired = 1'b0;
    xp = 1'b0;
    loop = 1'b0;
    mute = 1'b0;
    test_cmd = 1'b0;
    txi = TXI_INFO0;
    nxt_s = s_ff;

    // bit and frame timing; free-running, nothing aligns it
    bit_end = s_ff.bit_cyc == BIT_LAST;
    ft = bit_end && s_ff.bit_idx == FB_LAST;
    nxt_s.bit_cyc = bit_end ? '0 : s_ff.bit_cyc + 1'b1;
    if (bit_end) begin
      nxt_s.bit_idx = (s_ff.bit_idx == FB_LAST) ? 6'h00 :
        s_ff.bit_idx + 6'h01;
    end
    nxt_s.frame_start = ft;

    sw = s_ff.cfg[CFG_SW_BIT];
    mf_en = s_ff.sqtx[SQTX_MFEN_BIT];
    // anything but INFO 0 counts as line activity
    non_idle = rx_info != RXI_INFO0;
    expired = s_ff.tmr == TMR_LAST;
    test_cmd = cmd == CI_SINGLE_PULSE || cmd == CI_CONT_PULSE;
    nxt_s.prev_cmd = cmd;
    // synchroniser still shows its reset value for two cycles
    if (s_ff.warm != 2'h2) begin
      nxt_s.warm = s_ff.warm + 2'h1;
    end

    // activation state machine
    case (s_ff.st)
      L1_RESET: begin
        if (cmd != CI_CLEAR) begin
          nxt_s.st = L1_DEACT;
        end
      end
      L1_DEACT: begin
        // loop request starts activation as well
        if (cmd == CI_ACT_REQ || cmd == CI_LOOP_REQ) begin
          nxt_s.st = L1_PEND;
        end
      end
      L1_PEND: begin
        if (cmd == CI_DEACT_REQ) begin
          nxt_s.st = L1_DEACT;
        end else if ((cmd == CI_ACT_IND || cmd == CI_LOOP_CONF) &&
            rx_info == RXI_INFO3) begin
          nxt_s.st = L1_ACT;
        end
      end
      L1_ACT: begin
        if (cmd == CI_DEACT_REQ) begin
          nxt_s.st = L1_DEACT;
        end
      end
      L1_TEST: begin
        if (!test_cmd) begin
          nxt_s.st = L1_DEACT;
        end
      end
      default: begin
        nxt_s.st = L1_RESET;
      end
    endcase
    if (test_cmd && s_ff.st != L1_TEST) begin
      nxt_s.st = L1_TEST;
    end
    // clear command holds the machine in reset
    // software mode parks the internal machine
    // no false command from the flushing synchroniser
    if (cmd == CI_CLEAR || sw || s_ff.warm != 2'h2) begin
      nxt_s.st = L1_RESET;
    end

    // activity timer, restarts whenever the line idles
    if (s_ff.st == L1_DEACT && non_idle) begin
      nxt_s.tmr = expired ? s_ff.tmr : s_ff.tmr + 1'b1;
    end else begin
      nxt_s.tmr = '0;
    end

    // indication toward the highway
    case (s_ff.st)
      // interim while timing activity, else ack
      L1_DEACT: begin
        nxt_s.ci_ind = (non_idle && !expired) ? CI_INTERIM :
          CI_DEACT_ACK;
      end
      L1_PEND: begin
        nxt_s.ci_ind = CI_ACT_REQ;
      end
      L1_ACT: begin
        nxt_s.ci_ind = CI_ACT_IND;
      end
      default: begin
        nxt_s.ci_ind = CI_INTERIM;
      end
    endcase

    // transmitter selection
    if (sw) begin
      txi = s_ff.lcmd;
    end else begin
      case (s_ff.st)
        L1_PEND: txi = TXI_INFO2;
        L1_ACT: txi = TXI_INFO4;
        L1_TEST: txi = (cmd == CI_SINGLE_PULSE) ? TXI_SINGLE : TXI_CONT;
        default: txi = TXI_INFO0;
      endcase
    end
    nxt_s.tx_info = txi;

    // loopback 2 under the loop commands
    loop = !sw && ((s_ff.st == L1_PEND && cmd == CI_LOOP_REQ) ||
      (s_ff.st == L1_ACT && cmd == CI_LOOP_CONF));
    nxt_s.loop = loop;
    // four muted frames once confirm is first seen while already active
    if (loop && cmd == CI_LOOP_CONF && s_ff.prev_cmd != CI_LOOP_CONF) begin
      nxt_s.mute = MUTE_INIT;
    end else if (ft && s_ff.mute != 3'h0) begin
      nxt_s.mute = s_ff.mute - 3'h1;
    end
    mute = s_ff.mute != 3'h0;
    xp = sw ? (s_ff.lcmd == TXI_INFO4) : (s_ff.st == L1_ACT);

    // test pulse patterns, changed at bit edges
    if (bit_end) begin
      nxt_s.pp = 1'b0;
      nxt_s.pn = 1'b0;
      if (s_ff.tx_info == TXI_SINGLE && nxt_s.bit_idx == 6'h00) begin
        nxt_s.pp = s_ff.pol_single;
        nxt_s.pn = !s_ff.pol_single;
      end else if (s_ff.tx_info == TXI_CONT) begin
        nxt_s.pp = s_ff.pol_cont;
        nxt_s.pn = !s_ff.pol_cont;
      end
      nxt_s.pol_cont = !s_ff.pol_cont;
      if (ft) begin
        nxt_s.pol_single = !s_ff.pol_single;
      end
    end

    // received frame capture
    if (rx_frame_valid) begin
      nxt_s.rx_b1_l = rx_b1;
      nxt_s.rx_b2_l = rx_b2;
      nxt_s.rx_d_l = rx_d;
      // Q rides with the frame whose aux bit went out ONE
      if (mf_en && s_ff.tx_fa) begin
        nxt_s.q_sh[s_ff.slot] = rx_fa;
      end
    end

    // register bus, handshakes
    awready = !s_ff.aw_h && !s_ff.bv;
    wready = !s_ff.w_h && !s_ff.bv;
    arready = !s_ff.rv;
    if (awvalid && awready) begin
      nxt_s.aw_h = 1'b1;
      nxt_s.awa = awaddr;
    end
    if (wvalid && wready) begin
      nxt_s.w_h = 1'b1;
      nxt_s.wd = wdata[7:0];
      nxt_s.ws = wstrb[0];
    end
    if (s_ff.bv && bready) begin
      nxt_s.bv = 1'b0;
    end
    if (s_ff.aw_h && s_ff.w_h) begin
      nxt_s.aw_h = 1'b0;
      nxt_s.w_h = 1'b0;
      nxt_s.bv = 1'b1;
      nxt_s.br = RESP_OKAY;
      case (s_ff.awa)
        OFS_CONFIG: if (s_ff.ws) nxt_s.cfg = s_ff.wd[3:0];
        OFS_LINE_CMD: if (s_ff.ws) nxt_s.lcmd = s_ff.wd[2:0];
        OFS_SQ_TX: if (s_ff.ws) nxt_s.sqtx = s_ff.wd[4:0];
        OFS_LINE_STAT, OFS_SQ_RX, OFS_STATE: nxt_s.br = RESP_OKAY;
        default: nxt_s.br = RESP_SLVERR;
      endcase
    end
    if (s_ff.rv && rready) begin
      nxt_s.rv = 1'b0;
    end
    if (arvalid && arready) begin
      nxt_s.rv = 1'b1;
      nxt_s.rr = RESP_OKAY;
      case (araddr)
        OFS_CONFIG: nxt_s.rd = {4'h0, s_ff.cfg};
        OFS_LINE_CMD: nxt_s.rd = {5'h00, s_ff.lcmd};
        OFS_LINE_STAT: begin
          nxt_s.rd = {5'h00, s_ff.stat};
          // reading the status clears its interrupt
          nxt_s.rsc_irq = 1'b0;
        end
        OFS_SQ_RX: begin
          // latched Q bits; reading services both S/Q events
          nxt_s.rd = {4'h0, s_ff.q_rx};
          nxt_s.mf_irq = 1'b0;
          nxt_s.qc_irq = 1'b0;
        end
        OFS_SQ_TX: nxt_s.rd = {3'h0, s_ff.sqtx};
        OFS_STATE: nxt_s.rd = {1'b0, s_ff.st, s_ff.ci_ind};
        default: begin
          nxt_s.rd = 8'h00;
          nxt_s.rr = RESP_SLVERR;
        end
      endcase
    end

    // status follows the line; change flags after clears win
    nxt_s.stat = {non_idle, rx_info};
    if (nxt_s.stat != s_ff.stat && !s_ff.cfg[CFG_RSC_MASK_BIT]) begin
      nxt_s.rsc_irq = 1'b1;
    end

    // frame transmit and highway data
    if (ft) begin
      // one register stage for B1, B2 and D alike
      nxt_s.tx_b1 = (xp || loop) ? hw_b1_in : 8'hFF;
      nxt_s.tx_b2 = (xp || loop) ? hw_b2_in : 8'hFF;
      // a blocked highway gets no D access
      nxt_s.tx_d = ((xp || loop) && !d_blk) ? hw_d_in : 2'h3;
      // echo forced to zero inside the loop
      nxt_s.tx_e = loop ? 2'h0 : s_ff.rx_d_l;
      if (loop) begin
        nxt_s.hw_b1 = mute ? 8'h00 : hw_b1_in;
        nxt_s.hw_b2 = mute ? 8'h00 : hw_b2_in;
        nxt_s.hw_d = mute ? 2'h0 : hw_d_in;
      end else begin
        // ones toward the highway unless transparent
        nxt_s.hw_b1 = xp ? s_ff.rx_b1_l : 8'hFF;
        nxt_s.hw_b2 = xp ? s_ff.rx_b2_l : 8'hFF;
        nxt_s.hw_d = xp ? s_ff.rx_d_l : 2'h3;
      end
      if (mf_en) begin
        // aux bit ONE every fifth frame, M only in the first
        nxt_s.tx_fa = s_ff.sub == 3'h0;
        nxt_s.tx_m = s_ff.sub == 3'h0 && s_ff.slot == 2'h0;
        // S1 slot bit every fifth frame
        nxt_s.tx_s = (s_ff.sub == 3'h0) ? s_ff.s_act[s_ff.slot] : 1'b0;
        nxt_s.sub = (s_ff.sub == SUB_LAST) ? 3'h0 : s_ff.sub + 3'h1;
        if (s_ff.sub == SUB_LAST) begin
          nxt_s.slot = s_ff.slot + 2'h1;
        end
        // multiframe boundary latches S/Q for the host
        if (s_ff.sub == SUB_LAST && s_ff.slot == SLOT_LAST) begin
          nxt_s.q_rx = s_ff.q_sh;
          nxt_s.s_act = s_ff.sqtx[3:0];
          if (s_ff.cfg[CFG_MF_IRQ_EN_BIT]) begin
            nxt_s.mf_irq = 1'b1;
          end
          if (s_ff.cfg[CFG_QC_IRQ_EN_BIT] && s_ff.q_sh != s_ff.q_rx) begin
            nxt_s.qc_irq = 1'b1;
          end
        end
      end else begin
        nxt_s.tx_fa = 1'b0;
        nxt_s.tx_m = 1'b0;
        nxt_s.tx_s = 1'b0;
        nxt_s.sub = 3'h0;
        nxt_s.slot = 2'h0;
        nxt_s.s_act = s_ff.sqtx[3:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.st <= L1_RESET;
      s_ff.ci_ind <= CI_INTERIM;
      s_ff.tx_info <= TXI_INFO0;
      s_ff.cfg <= CFG_RST;
      s_ff.lcmd <= LCMD_RST;
      s_ff.sqtx <= SQTX_RST;
      s_ff.tx_b1 <= 8'hFF;
      s_ff.tx_b2 <= 8'hFF;
      s_ff.tx_d <= 2'h3;
      s_ff.hw_b1 <= 8'hFF;
      s_ff.hw_b2 <= 8'hFF;
      s_ff.hw_d <= 2'h3;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign bvalid = s_ff.bv;
  assign bresp = s_ff.br;
  assign rvalid = s_ff.rv;
  assign rresp = s_ff.rr;
  assign rdata = {24'h000000, s_ff.rd};
  assign ci_ind = s_ff.ci_ind;
  assign hw_b1_out = s_ff.hw_b1;
  assign hw_b2_out = s_ff.hw_b2;
  assign hw_d_out = s_ff.hw_d;
  assign tx_frame_start = s_ff.frame_start;
  assign tx_info = s_ff.tx_info;
  assign tx_b1 = s_ff.tx_b1;
  assign tx_b2 = s_ff.tx_b2;
  assign tx_d = s_ff.tx_d;
  assign tx_e = s_ff.tx_e;
  assign tx_fa = s_ff.tx_fa;
  assign tx_m = s_ff.tx_m;
  assign tx_s = s_ff.tx_s;
  assign tx_pulse_p = s_ff.pp;
  assign tx_pulse_n = s_ff.pn;
  assign loop2_closed = s_ff.loop;
  assign multiframe_tick_irq = s_ff.mf_irq;
  assign q_change_irq = s_ff.qc_irq;
  assign receive_status_change_irq = s_ff.rsc_irq;
endmodule
`default_nettype wire

// file: hdl/s_l1_pkg.sv
/*
  Constants, codes, register map and state type of the S/T layer-1
  multiframe controller.
  Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package s_l1_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int BIT_RATE_HZ = 192_000;
  // longest whole number of cycles within one line bit
  localparam int BIT_CYCLES = CLK_HZ / BIT_RATE_HZ;
  localparam int FRAME_BITS = 48;
  localparam int SUB_FRAMES = 5;
  localparam int S_SLOTS = 4;
  localparam int DEACT_TMR_MS = 8;
  localparam int DEACT_CYCLES = CLK_HZ / 1000 * DEACT_TMR_MS;
  localparam int LOOP_MUTE_FRAMES = 4;

  // control channel codes, commands and indications
  localparam logic [3:0] CI_INTERIM = 4'h0;
  localparam logic [3:0] CI_DEACT_REQ = CI_INTERIM;
  localparam logic [3:0] CI_CLEAR = 4'h1;
  localparam logic [3:0] CI_SINGLE_PULSE = 4'h2;
  localparam logic [3:0] CI_CONT_PULSE = 4'h3;
  localparam logic [3:0] CI_ACT_REQ = 4'h8;
  localparam logic [3:0] CI_LOOP_REQ = 4'hA;
  localparam logic [3:0] CI_ACT_IND = 4'hC;
  localparam logic [3:0] CI_LOOP_CONF = 4'hE;
  localparam logic [3:0] CI_DEACT_ACK = 4'hF;

  // transmit info selection, also the tx_info_select field
  localparam logic [2:0] TXI_INFO0 = 3'h0;
  localparam logic [2:0] TXI_SINGLE = 3'h1;
  localparam logic [2:0] TXI_INFO2 = 3'h2;
  localparam logic [2:0] TXI_INFO4 = 3'h3;
  localparam logic [2:0] TXI_CONT = 3'h4;

  // received info class from the deframer
  localparam logic [1:0] RXI_INFO0 = 2'h0;
  localparam logic [1:0] RXI_INFO3 = 2'h1;

  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_LINE_CMD = 8'h04;
  localparam logic [7:0] OFS_LINE_STAT = 8'h08;
  localparam logic [7:0] OFS_SQ_RX = 8'h0C;
  localparam logic [7:0] OFS_SQ_TX = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;

  localparam int CFG_SW_BIT = 0;
  localparam int CFG_MF_IRQ_EN_BIT = 1;
  localparam int CFG_QC_IRQ_EN_BIT = 2;
  localparam int CFG_RSC_MASK_BIT = 3;
  localparam int SQTX_MFEN_BIT = 4;
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam logic [2:0] LCMD_RST = 3'h0;
  localparam logic [4:0] SQTX_RST = 5'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    L1_RESET = 3'b000,
    L1_DEACT = 3'b001,
    L1_PEND = 3'b010,
    L1_ACT = 3'b011,
    L1_TEST = 3'b100
  } l1_state_e;
endpackage

// file: hdl/pin_sync2.sv
/*
  Two-stage synchroniser for a group of level inputs.
  Assumes the inputs are quasi-static levels from pins.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
  parameter int W = 1
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, high
  input wire logic [W-1:0] d, // asynchronous levels
  output logic [W-1:0] q // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_s;

  sync_s s_ff;
  sync_s nxt_s;

  // only the second stage is visible outside
  always_comb begin
    nxt_s = s_ff;
    nxt_s.meta = d;
    nxt_s.q = s_ff.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q = s_ff.q;
endmodule
`default_nettype wire

// file: verif/s_bus_layer1_multiframe_ctrl_properties.sv
/* Port checker for the S/T layer-1 controller.
   Assumes the block's own port names and a single clock. */
`timescale 1ns/1ps
`default_nettype none
module s_l1_checker (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic [3:0] ci_cmd_pin, // command
  input wire logic [3:0] ci_ind, // indication
  input wire logic bvalid, // write answer
  input wire logic bready, // answer taken
  input wire logic [1:0] bresp, // write code
  input wire logic rvalid, // read answer
  input wire logic rready, // answer taken
  input wire logic [31:0] rdata, // read data
  input wire logic [7:0] hw_b1_out, // to highway
  input wire logic tx_frame_start, // frame pulse
  input wire logic [7:0] tx_b1, // line B1
  input wire logic [1:0] tx_e, // echo
  input wire logic tx_fa, // aux bit
  input wire logic tx_m, // multiframe bit
  input wire logic loop2_closed // loop 2
);
  logic [4:0] gap_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // frames since the last aux ONE, saturating
  always_ff @(posedge clk) begin
    if (rst)
      gap_ff <= 5'h00;
    else if (tx_frame_start)
      gap_ff <= tx_fa ? 5'h01 : gap_ff + {4'h0, gap_ff != 5'h1F};
  end
  sequence clr_held;
    (ci_cmd_pin == 4'h1) [*6];
  endsequence
  a_m_with_fa: assert property (tx_m |-> tx_fa)
    else $error("multiframe bit without aux bit");
  a_fa_gap: assert property (
    tx_frame_start && tx_fa && !tx_m && gap_ff != 5'h00 |-> gap_ff == 5'h05)
    else $error("aux bit ONE off its five-frame spacing");
  a_frame_hold: assert property (
    !tx_frame_start |-> $stable(tx_b1) && $stable(tx_fa))
    else $error("frame field moved mid-frame");
  a_echo_zero: assert property (
    tx_frame_start && loop2_closed && $past(loop2_closed) |-> tx_e == 2'h0)
    else $error("echo not zero in loop");
  a_deact_ones: assert property (
    tx_frame_start && $past(ci_ind) == 4'hF && !loop2_closed |->
    hw_b1_out == 8'hFF)
    else $error("highway not ones when deactivated");
  a_bresp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  a_clear_interim: assert property (clr_held |-> ci_ind == 4'h0)
    else $error("clear command without interim code");
endmodule
bind s_bus_layer1_multiframe_ctrl s_l1_checker i_chk (.*);
`default_nettype wire

// file: verif/te_model.sv
/* Terminal model: answers each downstream frame with an upstream one.
   Assumes frame pulses and the M bit from the block on clk. */
`timescale 1ns/1ps
`default_nettype none
module te_model (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic tx_frame_start, // downstream frame
  input wire logic tx_m, // multiframe start
  input wire logic [3:0] q, // Q bits to send
  input wire logic [7:0] b1, // B1 to send
  output logic rx_frame_valid, // upstream frame
  output logic rx_fa, // aux bit
  output logic [7:0] rx_b1, // B1
  output logic [7:0] rx_b2, // B2
  output logic [1:0] rx_d // D
);
  logic [4:0] idx;
  logic f;
  always_ff @(posedge clk) begin
    if (rst)
      idx <= 5'h1F;
    else if (tx_frame_start)
      idx <= tx_m ? 5'h00 : idx + 5'h01;
    rx_frame_valid <= tx_frame_start && !rst;
  end
  assign f = (idx < 5'h14 && idx % 5 == 0) ? q[idx / 5] : 1'h0;
  // junk outside a frame, so a late sample cannot pass
  assign rx_fa = rx_frame_valid ? f : !f;
  assign rx_b1 = rx_frame_valid ? b1 : ~b1;
  assign rx_b2 = rx_frame_valid ? ~b1 : b1;
  assign rx_d = rx_frame_valid ? b1[1:0] : ~b1[1:0];
endmodule
`default_nettype wire

// file: verif/s_bus_layer1_multiframe_ctrl_bench.sv
/* Bench for the S/T layer-1 controller.
   Assumes te_model on the line side and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module s_bus_layer1_multiframe_ctrl_bench;
  import s_l1_pkg::*;
  logic clk, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, d_block_pin = 0, awready, wready, bvalid, arready;
  logic rvalid, rx_frame_valid, rx_fa, tx_frame_start, tx_fa, tx_m, tx_s;
  logic tx_pulse_p, tx_pulse_n, loop2_closed, multiframe_tick_irq, pp, pn;
  logic q_change_irq, receive_status_change_irq;
  logic [7:0] awaddr = 0, araddr = 0, hw_b1_in = 8'hC3, hw_b2_in = 8'h3C;
  logic [7:0] b1 = 8'h5A, hw_b1_out, hw_b2_out, rx_b1, rx_b2, tx_b1, tx_b2;
  logic [31:0] wdata = 0, rdata, rv;
  logic [3:0] wstrb = 4'hF, ci_cmd_pin = 4'h1, q = 4'hB, ci_ind, s_seen;
  logic [1:0] hw_d_in = 2'h1, rx_info = 0, bresp, rresp, rsp, hw_d_out;
  logic [1:0] rx_d, tx_d, tx_e, sk;
  logic [2:0] tx_info;
  int errors, compares, np, nn;
  logic [7:0] ra [4] = '{OFS_CONFIG, OFS_LINE_CMD, OFS_SQ_TX, 8'h18};
  logic [31:0] rw [4] = '{32'h0E, 32'h02, 32'h1F, 32'h55};
  logic [31:0] re [4] = '{32'h0E, 32'h02, 32'h1F, 32'h00};
  logic [1:0] rr [4] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR};
  s_bus_layer1_multiframe_ctrl #(.BIT_CYCLES_P(4), .DEACT_CYCLES_P(50))
    i_dut (.*);
  te_model i_te (.*);
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task end_sim;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task wf(input int n);
    repeat (n) @(posedge clk iff tx_frame_start);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (pa || pw) begin
      @(negedge clk);
      pa = pa && !awready;
      pw = pw && !wready;
      @(posedge clk);
      awvalid <= pa;
      wvalid <= pw;
    end
    do @(negedge clk); while (!bvalid);
    rsp = bresp;
    @(posedge clk);
    bready <= 1'h0;
    #1;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'h0;
    do @(negedge clk); while (!rvalid);
    rv = rdata;
    rsp = rresp;
    @(posedge clk);
    rready <= 1'h0;
    #1;
  endtask
  // S slots seen on the line and test pulse edges
  always @(negedge clk) begin
    if (tx_frame_start && tx_fa) begin
      sk = tx_m ? 2'h0 : sk + 2'h1;
      s_seen[sk] = tx_s;
    end
    np = np + (tx_pulse_p && !pp);
    nn = nn + (tx_pulse_n && !pn);
    pp = tx_pulse_p;
    pn = tx_pulse_n;
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      wr(ra[i], rw[i]);
      chk(rsp, rr[i]);
      rd(ra[i]);
      chk(rv, re[i]);
      chk(rsp, rr[i]);
    end
    @(posedge clk) rst <= 1'h1;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4));
      chk(rv, 0);
    end
    @(posedge clk) rx_info <= 2'h1;
    ci_cmd_pin <= 4'h8;
    wf(3);
    chk(hw_b1_out, 8'hFF);
    @(posedge clk) ci_cmd_pin <= 4'hC;
    wf(3);
    chk(ci_ind, 4'hC);
    chk(hw_b1_out, b1);
    chk(tx_b1, hw_b1_in);
    chk({hw_b2_out, hw_d_out, tx_b2}, {~b1, b1[1:0], hw_b2_in});
    chk({tx_fa, tx_m, tx_s}, 0);
    @(posedge clk) d_block_pin <= 1'h1;
    wf(3);
    chk(tx_d, 2'h3);
    wr(OFS_CONFIG, 32'h06);
    wr(OFS_SQ_TX, 32'h16);
    wf(45);
    chk(s_seen, 4'h6);
    chk(multiframe_tick_irq, 1);
    chk(q_change_irq, 1);
    rd(OFS_SQ_RX);
    chk(rv, 32'hB);
    chk({q_change_irq, multiframe_tick_irq}, 0);
    @(posedge clk) ci_cmd_pin <= 4'hE;
    repeat (8) @(posedge clk);
    wf(1);
    chk(loop2_closed, 1);
    chk(hw_b1_out, 0);
    wf(5);
    chk(hw_b1_out, hw_b1_in);
    chk(tx_e, 0);
    chk({hw_b2_out, hw_d_out}, {hw_b2_in, hw_d_in});
    for (int m = 0; m < 2; m++) begin
      @(posedge clk) ci_cmd_pin <= 4'h0;
      wf(2);
      @(posedge clk) ci_cmd_pin <= 4'h2 + 4'(m);
      wf(2);
      np = 0;
      nn = 0;
      repeat (768) @(posedge clk);
      chk(np, m ? 96 : 2);
      chk(nn, m ? 96 : 2);
    end
    @(posedge clk) ci_cmd_pin <= 4'h1;
    rx_info <= 2'h0;
    repeat (8) @(posedge clk);
    ci_cmd_pin <= 4'h0;
    repeat (8) @(posedge clk);
    #1 chk(ci_ind, 4'hF);
    @(posedge clk) rx_info <= 2'h2;
    repeat (8) @(posedge clk);
    #1 chk(ci_ind, 0);
    repeat (60) @(posedge clk);
    #1 chk(ci_ind, 4'hF);
    chk(receive_status_change_irq, 1);
    rd(OFS_LINE_STAT);
    chk(rv, 32'h6);
    chk(receive_status_change_irq, 0);
    @(posedge clk) ci_cmd_pin <= 4'hA;
    wf(2);
    chk(loop2_closed, 1);
    chk(hw_b1_out, hw_b1_in);
    chk(tx_e, 0);
    wr(OFS_CONFIG, 32'h07);
    wr(OFS_LINE_CMD, 32'h03);
    wf(2);
    chk(tx_info, TXI_INFO4);
    chk(ci_ind, CI_INTERIM);
    chk(hw_b1_out, b1);
    end_sim;
  end
endmodule
`default_nettype wire
